// *** logic/link_cfg_pkg.sv ***
// package: register map, field layout and types for the link configuration block
// =====================================================================
package link_cfg_pkg;

  // =====================================================================
  // bus geometry
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 32;
  localparam int          BE_W         = 4;

  // =====================================================================
  // byte offsets
  localparam logic [3:0]  OFS_LINK_CFG = 4'h0;
  localparam logic [3:0]  OFS_IRQ_EN   = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STAT = 4'h8;

  // =====================================================================
  // field positions
  localparam int          POS_RPT      = 5;
  localparam int          POS_POL_LO   = 3;
  localparam int          POS_POL_HI   = 4;
  localparam int          POS_QSEL     = 1;
  localparam int          POS_DET_IRQ  = 6;
  localparam int          POS_DET_RAW  = 0;

  // =====================================================================
  // values
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
  localparam logic [3:0]  ONEHOT_NONE  = 4'h0;

  typedef enum logic [1:0] {
    POL_ONCE_AUTH = 2'b00,
    POL_REG_CTRL  = 2'b01,
    POL_ALWAYS    = 2'b10,
    POL_INBAND    = 2'b11
  } enc_policy_t;

  typedef struct packed {
    logic        repeater_mode_en;
    enc_policy_t enc_policy;
    logic        rx_detect_qualify_sel;
  } link_cfg_t;

  localparam link_cfg_t CFG_RESET = '{1'b0, POL_ONCE_AUTH, 1'b0};

endpackage

// *** logic/bus_handshake.sv ***
// waitrequest generator: one wait cycle per access, then a one-cycle accept
module bus_handshake
  import link_cfg_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // request side
  input  wire logic request_in,
  input  wire logic ready_in,
  // answer side
  output logic      waitrequest_out,
  output logic      accept_out
);

  logic next_wait;

  // waitrequest drops for exactly one cycle, which is the accepting edge
  always_comb begin
    next_wait = 1'b1;
    if (request_in && waitrequest_out && ready_in) begin
      next_wait = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      waitrequest_out <= 1'b1;
    end else begin
      waitrequest_out <= next_wait;
    end
  end

  assign accept_out = request_in && !waitrequest_out;

endmodule

// *** logic/rx_detect_tracker.sv ***
// receiver-detect condition, its qualification and the sticky detect flag
module rx_detect_tracker
  import link_cfg_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // link side
  input  wire logic detect_in,
  input  wire logic lock_in,
  input  wire logic qualify_sel_in,
  // software side
  input  wire logic clear_in,
  output logic      cond_out,
  output logic      status_out
);

  logic next_cond;
  logic next_status;

  always_comb begin
    if (qualify_sel_in) begin
      next_cond = detect_in && lock_in;
    end else begin
      next_cond = detect_in;
    end
    // a new detection in the clearing cycle survives: set beats clear
    next_status = (next_cond && !cond_out) || (status_out && !clear_in);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cond_out   <= 1'b0;
      status_out <= 1'b0;
    end else begin
      cond_out   <= next_cond;
      status_out <= next_status;
    end
  end

endmodule

// *** logic/link_cfg_top.sv ***
// link configuration register bank behind an avalon-mm slave
module link_cfg_top
  import link_cfg_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  // strap
  input  wire logic              REPEATER_STRAP_IN,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
  input  wire logic [BE_W-1:0]   AVS_BYTEENABLE_IN,
  output logic [DATA_W-1:0]      AVS_READDATA_OUT,
  output logic                   AVS_WAITREQUEST_OUT,
  // downstream receiver status
  input  wire logic              RX_DETECT_IN,
  input  wire logic              RX_LOCK_IN,
  // configuration outputs
  output link_cfg_t              CFG_OUT,
  output logic [3:0]             ENC_POLICY_ONEHOT_OUT,
  output logic                   IRQ_OUT
);

  // =====================================================================
  // state
  link_cfg_t          cfg;
  link_cfg_t          next_cfg;
  logic               init_done;
  logic               next_init_done;
  logic               rx_detect_irq_enable;
  logic               next_irq_enable;
  logic [DATA_W-1:0]  next_readdata;
  logic [3:0]         next_onehot;
  logic               next_irq;
  logic               accept;
  logic               rd_launch;
  logic               wr_acc;
  logic               status_clear;
  logic               det_cond;
  logic               rx_detect_irq_status;

  // =====================================================================
  // bus handshake
  // waitrequest stays high until the strap has been taken, so no access
  // can race the power-up load of the policy field
  bus_handshake u_hs (
    .clk_in          (CLK_IN),
    .rst_n_in        (RST_N_IN),
    .request_in      (AVS_READ_IN || AVS_WRITE_IN),
    .ready_in        (init_done),
    .waitrequest_out (AVS_WAITREQUEST_OUT),
    .accept_out      (accept)
  );

  // read data must already stand while waitrequest is low, so it is
  // captured on the same edge that lowers waitrequest
  assign rd_launch    = AVS_READ_IN && AVS_WAITREQUEST_OUT && init_done;
  assign wr_acc       = accept && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
  assign status_clear = wr_acc && (AVS_ADDRESS_IN == OFS_IRQ_STAT)
                        && AVS_WRITEDATA_IN[POS_DET_IRQ];

  // =====================================================================
  // receiver detect
  rx_detect_tracker u_det (
    .clk_in         (CLK_IN),
    .rst_n_in       (RST_N_IN),
    .detect_in      (RX_DETECT_IN),
    .lock_in        (RX_LOCK_IN),
    .qualify_sel_in (cfg.rx_detect_qualify_sel),
    .clear_in       (status_clear),
    .cond_out       (det_cond),
    .status_out     (rx_detect_irq_status)
  );

  // =====================================================================
  // register next values
  always_comb begin
    next_cfg        = cfg;
    next_init_done  = 1'b1;
    next_irq_enable = rx_detect_irq_enable;
    if (!init_done) begin
      // strap is sampled once, on the first edge after reset release
      if (REPEATER_STRAP_IN) begin
        next_cfg.enc_policy = POL_INBAND;
      end else begin
        next_cfg.enc_policy = POL_ONCE_AUTH;
      end
    end else if (wr_acc) begin
      case (AVS_ADDRESS_IN)
        OFS_LINK_CFG: begin
          // bits 7, 6, 2 and 0 hold nothing, so writes there vanish
          next_cfg.repeater_mode_en      = AVS_WRITEDATA_IN[POS_RPT];
          next_cfg.enc_policy            =
            enc_policy_t'(AVS_WRITEDATA_IN[POS_POL_HI:POS_POL_LO]);
          next_cfg.rx_detect_qualify_sel = AVS_WRITEDATA_IN[POS_QSEL];
        end
        OFS_IRQ_EN: begin
          next_irq_enable = AVS_WRITEDATA_IN[POS_DET_IRQ];
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  // =====================================================================
  // read data, decoded policy and interrupt
  always_comb begin
    next_readdata = RD_ZERO;
    if (rd_launch) begin
      case (AVS_ADDRESS_IN)
        OFS_LINK_CFG: begin
          next_readdata[POS_RPT]               = cfg.repeater_mode_en;
          next_readdata[POS_POL_HI:POS_POL_LO] = cfg.enc_policy;
          next_readdata[POS_QSEL]              = cfg.rx_detect_qualify_sel;
        end
        OFS_IRQ_EN: begin
          next_readdata[POS_DET_IRQ] = rx_detect_irq_enable;
        end
        OFS_IRQ_STAT: begin
          next_readdata[POS_DET_IRQ] = rx_detect_irq_status;
          next_readdata[POS_DET_RAW] = det_cond;
        end
        default: begin
          next_readdata = RD_ZERO;
        end
      endcase
    end
    next_onehot = ONEHOT_NONE;
    case (cfg.enc_policy)
      POL_ONCE_AUTH: next_onehot[0] = 1'b1;
      POL_REG_CTRL:  next_onehot[1] = 1'b1;
      POL_ALWAYS:    next_onehot[2] = 1'b1;
      POL_INBAND:    next_onehot[3] = 1'b1;
      default:       next_onehot    = ONEHOT_NONE;
    endcase
    next_irq = rx_detect_irq_status && rx_detect_irq_enable;
  end

  // =====================================================================
  // registers
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfg                   <= CFG_RESET;
      init_done             <= 1'b0;
      rx_detect_irq_enable  <= 1'b0;
      AVS_READDATA_OUT      <= RD_ZERO;
      ENC_POLICY_ONEHOT_OUT <= ONEHOT_NONE;
      IRQ_OUT               <= 1'b0;
      CFG_OUT               <= CFG_RESET;
    end else begin
      cfg                   <= next_cfg;
      init_done             <= next_init_done;
      rx_detect_irq_enable  <= next_irq_enable;
      AVS_READDATA_OUT      <= next_readdata;
      ENC_POLICY_ONEHOT_OUT <= next_onehot;
      IRQ_OUT               <= next_irq;
      CFG_OUT               <= next_cfg;
    end
  end

endmodule

// *** tb/link_cfg_sva.sv ***
// checker: port-level relations of the link configuration bank
module link_cfg_sva
  import link_cfg_pkg::*;
(
  // clock, reset, strap, bus
  input wire logic              CLK_IN,
  input wire logic              RST_N_IN,
  input wire logic              REPEATER_STRAP_IN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic              AVS_READ_IN,
  input wire logic              AVS_WRITE_IN,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [BE_W-1:0]   AVS_BYTEENABLE_IN,
  input wire logic [DATA_W-1:0] AVS_READDATA_OUT,
  input wire logic              AVS_WAITREQUEST_OUT,
  // link status and outputs
  input wire logic              RX_DETECT_IN,
  input wire logic              RX_LOCK_IN,
  input wire link_cfg_t         CFG_OUT,
  input wire logic [3:0]        ENC_POLICY_ONEHOT_OUT,
  input wire logic              IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ====
  // edges since release; the strap load edge must not count as a stray change
  logic [1:0] up;
  logic [1:0] next_up;
  logic       taken;
  assign taken = !AVS_WAITREQUEST_OUT && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0]
                 && AVS_ADDRESS_IN == OFS_LINK_CFG;
  always_comb next_up = (up == 2'd3) ? up : up + 2'd1;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) up <= 2'd0;
    else up <= next_up;
  end
  // ====
  a_policy_onehot: assert property (
    up[1] |-> ENC_POLICY_ONEHOT_OUT == (4'h1 << $past(CFG_OUT.enc_policy)))
    else $error("onehot policy does not follow the field");
  a_strap_high: assert property (
    $rose(RST_N_IN) && REPEATER_STRAP_IN |=> CFG_OUT.enc_policy == POL_INBAND)
    else $error("strap high did not load in-band policy");
  a_strap_low: assert property (
    $rose(RST_N_IN) && !REPEATER_STRAP_IN |=> CFG_OUT.enc_policy == POL_ONCE_AUTH)
    else $error("strap low did not load once-authenticated policy");
  a_write_update: assert property (
    taken |=> CFG_OUT == {$past(AVS_WRITEDATA_IN[5:3]), $past(AVS_WRITEDATA_IN[1])})
    else $error("configuration write not applied");
  a_cfg_hold: assert property (
    up == 2'd3 && !taken |=> $stable(CFG_OUT))
    else $error("configuration changed without a write");
  a_reserved_read: assert property (
    !AVS_WAITREQUEST_OUT && AVS_READ_IN && AVS_ADDRESS_IN == OFS_LINK_CFG
    |-> AVS_READDATA_OUT == {26'h0, CFG_OUT[3:1], 1'b0, CFG_OUT[0], 1'b0})
    else $error("configuration readback wrong");
  // detect is taken two edges before the rise; an enable write can also raise it
  a_irq_cause: assert property (
    $rose(IRQ_OUT) && !$past(AVS_WRITE_IN, 2) |-> $past(RX_DETECT_IN, 2)
    && ($past(RX_LOCK_IN, 2) || !$past(CFG_OUT[0], 2)))
    else $error("interrupt rose without a qualified detect");
  a_irq_sticky: assert property (
    IRQ_OUT && !AVS_WRITE_IN && !$past(AVS_WRITE_IN) |=> IRQ_OUT)
    else $error("interrupt dropped without a write");
  a_wait_single: assert property (
    !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");
endmodule
bind link_cfg_top link_cfg_sva u_sva (
  .CLK_IN                (CLK_IN),
  .RST_N_IN              (RST_N_IN),
  .REPEATER_STRAP_IN     (REPEATER_STRAP_IN),
  .AVS_ADDRESS_IN        (AVS_ADDRESS_IN),
  .AVS_READ_IN           (AVS_READ_IN),
  .AVS_WRITE_IN          (AVS_WRITE_IN),
  .AVS_WRITEDATA_IN      (AVS_WRITEDATA_IN),
  .AVS_BYTEENABLE_IN     (AVS_BYTEENABLE_IN),
  .AVS_READDATA_OUT      (AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT   (AVS_WAITREQUEST_OUT),
  .RX_DETECT_IN          (RX_DETECT_IN),
  .RX_LOCK_IN            (RX_LOCK_IN),
  .CFG_OUT               (CFG_OUT),
  .ENC_POLICY_ONEHOT_OUT (ENC_POLICY_ONEHOT_OUT),
  .IRQ_OUT               (IRQ_OUT)
);

// *** tb/link_config_register_tb_top.sv ***
// testbench: link configuration register bank
module link_config_register_tb_top
  import link_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] wd; logic [7:0] rd; logic [3:0] oh;} row_t;
  row_t rows [4] = '{'{8'hff, 8'h3a, 4'h8}, '{8'h05, 8'h00, 4'h1},
                     '{8'h2a, 8'h2a, 4'h2}, '{8'hd0, 8'h10, 4'h4}};
  logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, rd = 1'b0, wr = 1'b0;
  logic det = 1'b0, lock = 1'b0, wait_o, irq;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, q, rdata;
  logic [BE_W-1:0]   be = 4'hf;
  logic [3:0]        oh;
  link_cfg_t         cfg;
  int                failures = 0, num_checks = 0;
  link_cfg_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .REPEATER_STRAP_IN(strap),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_o),
    .RX_DETECT_IN(det), .RX_LOCK_IN(lock), .CFG_OUT(cfg), .ENC_POLICY_ONEHOT_OUT(oh),
    .IRQ_OUT(irq));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ====
  task automatic final_report;
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", 32'h0, {31'h0, wait_o});
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, '0);
    chk(n, e, q);
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // ====
  initial begin
    do_reset(1'b1);
    rchk("strap_hi", OFS_LINK_CFG, 32'h18);
    foreach (rows[i]) begin
      acc(1'b1, OFS_LINK_CFG, {24'h0, rows[i].wd});
      rchk("cfg_rd", OFS_LINK_CFG, {24'h0, rows[i].rd});
      chk("onehot", {28'h0, rows[i].oh}, {28'h0, oh});
      chk("rpt", {31'h0, rows[i].rd[5]}, {31'h0, cfg.repeater_mode_en});
    end
    be <= 4'h0;
    acc(1'b1, OFS_LINK_CFG, 32'h0);
    be <= 4'hf;
    rchk("no_lane", OFS_LINK_CFG, 32'h10);
    acc(1'b1, 4'hc, 32'hff);
    rchk("unmapped", 4'hc, 32'h0);
    do_reset(1'b0);
    rchk("strap_lo", OFS_LINK_CFG, 32'h0);
    det <= 1'b1;
    repeat (4) @(posedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rchk("stat_set", OFS_IRQ_STAT, 32'h41);
    det <= 1'b0;
    acc(1'b1, OFS_IRQ_STAT, 32'h40);
    rchk("stat_clr", OFS_IRQ_STAT, 32'h0);
    acc(1'b1, OFS_IRQ_EN, 32'h40);
    rchk("en_rd", OFS_IRQ_EN, 32'h40);
    acc(1'b1, OFS_LINK_CFG, 32'h02);
    det <= 1'b1;
    repeat (5) @(posedge clk);
    chk("irq_nolock", 32'h0, {31'h0, irq});
    lock <= 1'b1;
    repeat (5) @(posedge clk);
    chk("irq_lock", 32'h1, {31'h0, irq});
    acc(1'b1, OFS_IRQ_STAT, 32'h40);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    acc(1'b1, OFS_LINK_CFG, 32'h0);
    det <= 1'b0;
    lock <= 1'b0;
    repeat (3) @(posedge clk);
    det <= 1'b1;
    repeat (4) @(posedge clk);
    chk("irq_det", 32'h1, {31'h0, irq});
    final_report();
  end
  // about 100 cycles expected; far longer means a hang
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule
